/* File: verilog/cfg_header_map.vh */
// Offsets, field positions and reset values of the bridge config header front end
// Function
// R1 - Support RO, sticky, RW and W1C field kinds
// R2 - Maker code in dword zero bits 15:0
// R3 - Part code in dword zero bits 31:16
// R4 - Command bit 0 gates primary I/O
// R5 - Command bit 1 gates primary memory
// R6 - Command bit 2 gates mastering and secondary response
// R7 - Command bit 3 reads zero, no special cycles
// R8 - Command bit 4 reads zero, no own invalidate
// R9 - Command bits 5, 7, 9 read zero
// R10 - Bit 6 lets parity events set status flag
// R11 - Bit 8 gates upstream error messages
// R12 - Bit 10 keeps legacy interrupt deasserted
// R13 - Status bit 24 sticky W1C on parity events
// R14 - Read-only and reserved command bits ignore writes
`ifndef CFG_HEADER_MAP_VH
`define CFG_HEADER_MAP_VH
`define IDENT_OFFSET 8'h00
`define CMD_STAT_OFFSET 8'h04
`define CMD_IO_BIT 0
`define CMD_MEM_BIT 1
`define CMD_MASTER_BIT 2
`define CMD_PARITY_BIT 6
`define CMD_ERRMSG_BIT 8
`define CMD_INTDIS_BIT 10
`define CMD_RW_MASK 16'h0547
`define CMD_RESET 16'h0000
`define STAT_PARITY_BIT 24
`define MAKER_IDENT_DEFAULT 16'hA5A5
`define PART_IDENT_DEFAULT 16'h5A5A
`endif

/* File: verilog/bridge_config_header_command.v */
// Configuration header identity, command register and linked parity status flag
`timescale 1ns/10ps
`include "cfg_header_map.vh"

module bridge_config_header_command #(
  // Arbitrary identity values
  parameter [15:0] MAKER_IDENT = `MAKER_IDENT_DEFAULT,
  parameter [15:0] PART_IDENT = `PART_IDENT_DEFAULT
) (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_i,
  // Configuration access
  input wire cfg_rd_i,
  input wire cfg_wr_i,
  input wire [7:0] cfg_addr_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  output wire [31:0] cfg_rdata_o,
  output wire cfg_rvalid_o,
  // Traffic and event inputs from bridge core
  input wire pri_io_req_i,
  input wire pri_mem_req_i,
  input wire sec_fwd_req_i,
  input wire poison_cpl_i,
  input wire poison_wr_i,
  input wire err_msg_req_i,
  input wire int_req_i,
  // Gated outputs to bridge core and pins
  output wire pri_io_accept_o,
  output wire pri_mem_accept_o,
  output wire sec_fwd_accept_o,
  output wire master_en_o,
  output wire parity_resp_en_o,
  output wire err_msg_send_o,
  output wire inta_n_o,
  output wire [15:0] command_o,
  output wire parity_flag_o
);

  reg [15:0] command_control_q;
  reg [15:0] command_control_d;
  reg parity_flag_q;
  reg parity_flag_d;
  reg [31:0] rdata_q;
  reg rvalid_q;
  reg io_acc_q;
  reg mem_acc_q;
  reg fwd_acc_q;
  reg err_msg_q;
  reg inta_n_q;
  wire cmd_hit;
  wire [15:0] wmask;
  wire parity_event;
  wire parity_clear;

  assign cmd_hit = (cfg_addr_i == `CMD_STAT_OFFSET);
  // Byte enables per lane of low half
  assign wmask = {{8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

  always @* begin
    command_control_d = command_control_q;
    if (cfg_wr_i && cmd_hit) begin
      // Only writable fields take data; the rest stay zero [R14] [R7] [R8] [R9]
      command_control_d = ((command_control_q & ~wmask) | (cfg_wdata_i[15:0] & wmask))
        & `CMD_RW_MASK; // [R1]
    end
  end

  // Parity flag sets only while response enabled [R10] [R13]
  assign parity_event = command_control_q[`CMD_PARITY_BIT] && (poison_cpl_i || poison_wr_i);
  // Writing one clears, zero keeps [R1]
  assign parity_clear = cfg_wr_i && cmd_hit && cfg_be_i[3] && cfg_wdata_i[`STAT_PARITY_BIT];

  always @* begin
    parity_flag_d = parity_flag_q;
    if (parity_clear) begin
      parity_flag_d = 1'b0;
    end
    // Set beats clear so a coincident event is kept
    if (parity_event) begin
      parity_flag_d = 1'b1; // [R13]
    end
  end

  always @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      command_control_q <= `CMD_RESET;
      parity_flag_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rvalid_q <= 1'b0;
      io_acc_q <= 1'b0;
      mem_acc_q <= 1'b0;
      fwd_acc_q <= 1'b0;
      err_msg_q <= 1'b0;
      inta_n_q <= 1'b1;
    end else begin
      command_control_q <= command_control_d;
      parity_flag_q <= parity_flag_d;
      rvalid_q <= cfg_rd_i;
      if (cfg_rd_i) begin
        if (cfg_addr_i == `IDENT_OFFSET) begin
          rdata_q <= {PART_IDENT, MAKER_IDENT}; // [R2] [R3]
        end else if (cmd_hit) begin
          rdata_q <= {7'h00, parity_flag_q, 8'h00, command_control_q};
        end else begin
          // Unmapped dwords read zero
          rdata_q <= 32'h00000000;
        end
      end
      io_acc_q <= pri_io_req_i && command_control_q[`CMD_IO_BIT]; // [R4]
      mem_acc_q <= pri_mem_req_i && command_control_q[`CMD_MEM_BIT]; // [R5]
      fwd_acc_q <= sec_fwd_req_i && command_control_q[`CMD_MASTER_BIT]; // [R6]
      err_msg_q <= err_msg_req_i && command_control_q[`CMD_ERRMSG_BIT]; // [R11]
      inta_n_q <= ~(int_req_i && !command_control_q[`CMD_INTDIS_BIT]); // [R12]
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign pri_io_accept_o = io_acc_q;
  assign pri_mem_accept_o = mem_acc_q;
  assign sec_fwd_accept_o = fwd_acc_q;
  assign master_en_o = command_control_q[`CMD_MASTER_BIT];
  assign parity_resp_en_o = command_control_q[`CMD_PARITY_BIT];
  assign err_msg_send_o = err_msg_q;
  assign inta_n_o = inta_n_q;
  assign command_o = command_control_q;
  assign parity_flag_o = parity_flag_q;

endmodule // bridge_config_header_command

/* File: sim/cfg_hdr_chk_asserts.sv */
// Checker of config header ports
`timescale 1ns/10ps
`include "cfg_header_map.vh"
module cfg_hdr_chk(input wire ref_clk_i,rst_i,cfg_rd_i,cfg_rvalid_o,pri_io_req_i,
input wire pri_mem_req_i,sec_fwd_req_i,int_req_i,pri_io_accept_o,pri_mem_accept_o,
input wire sec_fwd_accept_o,inta_n_o,input wire [7:0] cfg_addr_i,
input wire err_msg_req_i,err_msg_send_o,poison_cpl_i,poison_wr_i,parity_flag_o,
input wire parity_resp_en_o,master_en_o,
input wire [31:0] cfg_rdata_o,input wire [15:0] command_o);
default clocking @(posedge ref_clk_i); endclocking
default disable iff (rst_i);
a_read_ack: assert property (cfg_rd_i |=> cfg_rvalid_o) else $error("rd");
a_ack_cause: assert property (cfg_rvalid_o |-> $past(cfg_rd_i)) else $error("rv");
a_ident_read: assert property (cfg_rd_i && cfg_addr_i==0 |=>
 cfg_rdata_o=={`PART_IDENT_DEFAULT,`MAKER_IDENT_DEFAULT}) else $error("id");
a_io_gate: assert property (pri_io_accept_o==$past(pri_io_req_i&command_o[0]))
 else $error("io");
a_mem_gate: assert property (pri_mem_accept_o==$past(pri_mem_req_i&command_o[1]))
 else $error("mem");
a_fwd_gate: assert property (sec_fwd_accept_o==$past(sec_fwd_req_i&command_o[2]))
 else $error("fwd");
a_int_mask: assert property (inta_n_o==!$past(int_req_i&!command_o[10]))
 else $error("int");
a_ro_zero: assert property ((command_o&16'hFAB8)==0) else $error("ro");
a_err_gate: assert property (err_msg_send_o==$past(err_msg_req_i&command_o[8]))
 else $error("err");
a_flag_set: assert property (command_o[6]&&(poison_cpl_i||poison_wr_i) |=> parity_flag_o)
 else $error("flag");
a_parity_en: assert property (parity_resp_en_o==command_o[6]) else $error("pe");
a_master_en: assert property (master_en_o==command_o[2]) else $error("me");
cover property (parity_flag_o);
cover property (pri_io_accept_o);
cover property (!inta_n_o);
cover property (cfg_rvalid_o);
endmodule // cfg_hdr_chk
bind bridge_config_header_command cfg_hdr_chk chk_i(.*);

/* File: sim/root_cplx.sv */
// Root complex model issuing config accesses
`timescale 1ns/10ps
module root_cplx(input wire ref_clk_i,input wire [31:0] cfg_rdata_i,output reg rd_o=0,
output reg wr_o=0,output reg [7:0] addr_o=0,output reg [3:0] be_o=0,output reg [31:0] wdata_o=0);
task xfer(input w,input [7:0] a,input [3:0] b,input [31:0] d,output [31:0] q);
  begin
    @(negedge ref_clk_i);
    {rd_o,wr_o,addr_o,be_o,wdata_o}={!w,w,a,b,d};
    @(negedge ref_clk_i);
    // Released data flips so stale values never match
    {rd_o,wr_o,wdata_o}={2'b00,~d};
    q=cfg_rdata_i;
  end
endtask
endmodule // root_cplx

/* File: sim/bridge_config_header_command_bench.sv */
// Bench for config header front end
`timescale 1ns/10ps
`include "cfg_header_map.vh"
module bridge_config_header_command_bench;
reg ref_clk_i=0,rst_i=1; reg [6:0] ev=0; reg [31:0] q; integer fails=0,total_checks=0,cyc=0;
wire rd,wr,rv,flag; wire [7:0] ad; wire [3:0] be; wire [31:0] wd,rdat; wire [15:0] cmd; wire [6:0] o;
bridge_config_header_command dut(.ref_clk_i,.rst_i,.cfg_rd_i(rd),.cfg_wr_i(wr),.cfg_addr_i(ad),
.cfg_be_i(be),.cfg_wdata_i(wd),.cfg_rdata_o(rdat),.cfg_rvalid_o(rv),.pri_io_req_i(ev[0]),
.pri_mem_req_i(ev[1]),.sec_fwd_req_i(ev[2]),.poison_cpl_i(ev[3]),.poison_wr_i(ev[4]),
.err_msg_req_i(ev[5]),.int_req_i(ev[6]),.pri_io_accept_o(o[0]),.pri_mem_accept_o(o[1]),
.sec_fwd_accept_o(o[2]),.master_en_o(o[3]),.parity_resp_en_o(o[4]),.err_msg_send_o(o[5]),
.inta_n_o(o[6]),.command_o(cmd),.parity_flag_o(flag));
root_cplx rc(.ref_clk_i,.cfg_rdata_i(rdat),.rd_o(rd),.wr_o(wr),.addr_o(ad),.be_o(be),.wdata_o(wd));
initial forever #5 ref_clk_i=~ref_clk_i;
task end_of_test; begin if (fails==0 && total_checks>0) $display("Finished cleanly");
else $display("Finished with errors"); $finish; end endtask
always @(posedge ref_clk_i) begin cyc=cyc+1; if (cyc>400) begin fails=fails+1; end_of_test; end end
task chk(input [47:0] n,input [31:0] e,s); begin total_checks=total_checks+1;
if (s!==e) begin fails=fails+1; $display("CHECK FAILED %0s exp %h got %h",n,e,s); end end endtask
task rd32(input [7:0] a,input [31:0] e); begin rc.xfer(0,a,0,0,q); chk("rvalid",1,rv);
chk("rdata",e,q); end endtask
task wr32(input [7:0] a,input [3:0] b,input [31:0] d); rc.xfer(1,a,b,d,q); endtask
task t_ident; begin wr32(0,15,~0); rd32(0,{`PART_IDENT_DEFAULT,`MAKER_IDENT_DEFAULT});
rd32(8'h40,0); end endtask
task t_cmd; begin wr32(4,3,~0); chk("cmd",16'h0547,cmd);
rd32(4,32'h0547); end endtask
task t_gate(input [15:0] c); begin wr32(4,3,c); ev=7'h67; @(negedge ref_clk_i);
chk("gate",{c[10],c[8],c[6],c[2],c[2:0]},o); ev=0; end endtask
task t_par; begin wr32(4,3,0); ev=8; @(negedge ref_clk_i); chk("nflag",0,flag);
wr32(4,3,64); ev=16; @(negedge ref_clk_i); ev=0; chk("flag",1,flag);
rd32(4,32'h01000040); wr32(4,8,32'h01000000); chk("clear",0,flag); end endtask
initial begin repeat (2) @(negedge ref_clk_i); rst_i=0;
t_ident; t_cmd; t_gate(0); t_gate(16'h0547); t_par; end_of_test; end
endmodule // bridge_config_header_command_bench
